// ### safe_brake_output_control_test.sv
// Purpose: self-checking bench for the safe brake control block
// Assumes: block 0 two-pole, block 1 one-pole; 10 cycles per ms
// Notes:   block 0 uses normally open, block 1 normally closed feedback
`include "sbc_params.svh"
module safe_brake_output_control_test
    import sbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           clk = 0, rst_n = 0, torque = 1, stop = 0, run = 0, req = 0;
    sbc_cfg_s [1:0] cfg, cfg_one;
    logic [1:0]     fbk, drv_out, fb_err, stuck = 2'h0, drv_one, err_one;
    logic           two_term, err_react, two_one, react_one;
    int             n_mismatch = 0, compares = 0;
    initial cfg = {{1'h0, 1'h1, 2'h2, 17'h2, 17'h2}, {1'h0, 1'h1, 2'h1, 17'h2, 17'h2}};
    // second instance: one 1-pole block, feedback off
    always_comb
    begin
        cfg_one           = cfg;
        cfg_one[0].fbk_en = 1'h0;
        cfg_one[1].fbk_en = 1'h0;
    end
    sbc_brake_ctrl #(.NUM_BLOCKS(1), .BLK0_TYPE(`SBC_BLK_1POLE), .CYC_PER_MS(10)) DUT1 (
        .CLK(clk), .RST_N(rst_n),
        .TORQUE_OFF_STATE(torque), .SAFE_RUN_STATE(run), .CONTROLLED_STOP_ONE(stop),
        .DRIVE_RELEASE_REQ(req), .CFG(cfg_one), .BRAKE_FEEDBACK_IN(2'h0),
        .TWO_TERMINAL_BRAKE_OUT(two_one), .BRAKE_DRIVE_OUT(drv_one),
        .FEEDBACK_ERROR(err_one), .ERROR_REACTION(react_one));
    sbc_brake_ctrl #(.CYC_PER_MS(10)) DUT (.CLK(clk), .RST_N(rst_n),
        .TORQUE_OFF_STATE(torque), .SAFE_RUN_STATE(run), .CONTROLLED_STOP_ONE(stop),
        .DRIVE_RELEASE_REQ(req), .CFG(cfg), .BRAKE_FEEDBACK_IN(fbk),
        .TWO_TERMINAL_BRAKE_OUT(two_term), .BRAKE_DRIVE_OUT(drv_out),
        .FEEDBACK_ERROR(fb_err), .ERROR_REACTION(err_react));
    sbc_brake_model M0 (.clk(clk), .rst_n(rst_n), .drive(two_term),
        .contact(cfg[0].contact), .stuck(stuck[0]), .feedback(fbk[0]));
    sbc_brake_model M1 (.clk(clk), .rst_n(rst_n), .drive(drv_out[1]),
        .contact(cfg[1].contact), .stuck(stuck[1]), .feedback(fbk[1]));
    initial forever #4 clk = ~clk;
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic step(input logic t, s, r, q, e);
        @(posedge clk);
        torque <= t;
        stop <= s;
        run <= r;
        req <= q;
        repeat (3) @(posedge clk);
        #1;
        check(drv_out, {e, 1'b0});
        check({1'b0, two_term}, {1'b0, e});
        check(drv_one, {1'b0, e});
        check({1'b0, two_one}, 2'h0);
        repeat (27) @(posedge clk);
    endtask
    task automatic t_default();
        step(1, 0, 1, 1, 0);
        step(0, 0, 1, 0, 1);
        step(1, 0, 0, 1, 0);
        $display("t_default done");
    endtask
    task automatic t_pass();
        cfg[0].pass_en <= 1'h1;
        cfg[1].pass_en <= 1'h1;
        step(1, 0, 1, 1, 0);
        step(0, 0, 1, 1, 1);
        step(0, 0, 1, 0, 0);
        step(0, 0, 1, 1, 1);
        step(1, 0, 1, 1, 0);
        step(0, 0, 0, 0, 1);
        $display("t_pass done");
    endtask
    task automatic t_stop();
        step(0, 0, 1, 1, 1);
        step(0, 1, 1, 1, 0);
        step(1, 1, 1, 1, 0);
        step(0, 0, 1, 1, 1);
        check(fb_err, 2'h0);
        check({1'b0, err_react}, 2'h0);
        $display("t_stop done");
    endtask
    task automatic t_fault();
        @(posedge clk);
        stuck <= 2'h3;
        req <= 1'h0;
        repeat (12) @(posedge clk);
        #1;
        check(fb_err, 2'h0);
        repeat (30) @(posedge clk);
        #1;
        check(fb_err, 2'h3);
        check({1'b0, err_react}, 2'h1);
        @(posedge clk);
        stuck <= 2'h0;
        cfg[0].fbk_en <= 1'h0;
        cfg[1].fbk_en <= 1'h0;
        repeat (10) @(posedge clk);
        #1;
        check(fb_err, 2'h0);
        check({1'b0, err_react}, 2'h0);
        @(posedge clk);
        cfg[0].contact <= 2'h3;
        cfg[0].fbk_en <= 1'h1;
        repeat (5) @(posedge clk);
        #1;
        check(fb_err, 2'h1);
        check({1'b0, err_react}, 2'h1);
        @(posedge clk);
        cfg[0].contact <= 2'h1;
        cfg[0].fbk_en <= 1'h0;
        @(posedge clk);
        cfg[0].fbk_en <= 1'h1;
        cfg[1].fbk_en <= 1'h1;
        repeat (30) @(posedge clk);
        #1;
        check(fb_err, 2'h0);
        check({1'b0, err_react}, 2'h0);
        check(err_one, 2'h0);
        check({1'b0, react_one}, 2'h0);
        $display("t_fault done");
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #50us;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        t_default();
        t_pass();
        t_stop();
        t_fault();
        stop_test();
    end
endmodule // safe_brake_output_control_test

// ### sbc_brake_ctrl.sv
// Purpose: safe brake control, two blocks, with optional feedback check
// Assumes: all inputs synchronous to CLK; config static while running
// Notes:   block 0 may be 1-pole or 2-pole, block 1 is always 1-pole
`include "sbc_params.svh"

// Contract
// [R01] brake engages automatically whenever torque off state is active
// [R02] active brake function drives the assigned output to 0
// [R03] inactive brake function drives the assigned output to 1
// [R04] option, default off, passes drive brake request to safe output
// [R05] pass-through on and torque off: output 0, request ignored
// [R06] pass-through on and safe run: output follows drive request
// [R07] error-driven stop into torque off engages brake regardless of request
// [R08] optional feedback input, default off, behaviour set by configuration
// [R09] normally open: device returns 1 released, 0 applied
// [R10] normally closed: device returns 0 released, 1 applied
// [R11] contact type 1 is normally open, 2 is normally closed
// [R12] separate rise and fall feedback delays, 0 to 120000 ms, default 20
// [R13] at most two blocks: 1-pole plus 1-pole, or 2-pole plus 1-pole
// [R14] a 1-pole block drives a single-ended digital output
// [R15] a 2-pole block drives the two-terminal brake output
// [R16] feedback missing its level within the delay flags an error
module sbc_brake_ctrl
    import sbc_pkg::*;
#(
    parameter int      NUM_BLOCKS    = `SBC_NUM_BLOCKS,
    parameter logic    BLK0_TYPE     = `SBC_BLK_2POLE,
    parameter int      CYC_PER_MS    = `SBC_CYC_PER_MS
)(
    // clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    // module state
    input  wire logic                 TORQUE_OFF_STATE,
    input  wire logic                 SAFE_RUN_STATE,
    input  wire logic                 CONTROLLED_STOP_ONE,
    // drive controller request, 1 = release
    input  wire logic                 DRIVE_RELEASE_REQ,
    // per block configuration and feedback
    input  wire sbc_cfg_s [1:0]       CFG,
    input  wire logic [1:0]           BRAKE_FEEDBACK_IN,
    // outputs
    output logic                      TWO_TERMINAL_BRAKE_OUT,
    output logic [1:0]                BRAKE_DRIVE_OUT,
    output logic [1:0]                FEEDBACK_ERROR,
    output logic                      ERROR_REACTION
);

    logic [1:0]    drive;
    logic [1:0]    next_drive;
    sbc_fb_e [1:0] fb_state;
    sbc_fb_e [1:0] next_fb_state;
    logic [16:0]   ms_cnt [1:0];
    logic [16:0]   next_ms_cnt [1:0];
    logic [16:0]   div_cnt [1:0];
    logic [16:0]   next_div_cnt [1:0];
    logic [1:0]    next_err;
    logic          next_two_term;
    logic [1:0]    next_out;
    logic          next_reaction;
    logic [1:0]    expect_fb;
    logic [1:0]    cfg_ok;

    // brake demand: 1 = release
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (TORQUE_OFF_STATE || CONTROLLED_STOP_ONE) // [R01] [R05] [R07]
                next_drive[i] = 1'h0; // [R02]
            else if (CFG[i].pass_en && SAFE_RUN_STATE) // [R04]
                next_drive[i] = DRIVE_RELEASE_REQ; // [R06]
            else
                next_drive[i] = 1'h1; // [R03]
            if (i >= NUM_BLOCKS) // [R13]
                next_drive[i] = 1'h0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            drive <= 2'h0;
        else
            drive <= next_drive;
    end

    // feedback supervision
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            cfg_ok[i] = (CFG[i].contact == `SBC_CONTACT_NO) ||
                        (CFG[i].contact == `SBC_CONTACT_NC); // [R11]
            // released level 1 for normally open, 0 for normally closed
            expect_fb[i] = (CFG[i].contact == `SBC_CONTACT_NO) ? drive[i] : ~drive[i]; // [R09] [R10]
            next_fb_state[i] = fb_state[i];
            next_ms_cnt[i]   = ms_cnt[i];
            next_div_cnt[i]  = div_cnt[i];
            next_err[i]      = FEEDBACK_ERROR[i];
            if (!CFG[i].fbk_en || i >= NUM_BLOCKS) // [R08]
            begin
                next_fb_state[i] = SBC_FB_IDLE;
                next_err[i]      = 1'h0;
            end
            else
            begin
                case (fb_state[i])
                    SBC_FB_IDLE:
                    begin
                        if (!cfg_ok[i])
                        begin
                            next_fb_state[i] = SBC_FB_FAULT;
                        end
                        else if (drive[i] != next_drive[i])
                        begin
                            next_fb_state[i] = SBC_FB_WAIT;
                            next_ms_cnt[i]   = 17'h0;
                            next_div_cnt[i]  = 17'h0;
                        end
                        else if (BRAKE_FEEDBACK_IN[i] != expect_fb[i])
                            next_fb_state[i] = SBC_FB_FAULT; // [R16]
                    end
                    SBC_FB_WAIT:
                    begin
                        if (BRAKE_FEEDBACK_IN[i] == expect_fb[i])
                            next_fb_state[i] = SBC_FB_IDLE;
                        // rising delay when feedback is expected to go to 1
                        else if (ms_cnt[i] >= (expect_fb[i] ? CFG[i].ton_ms
                                                            : CFG[i].toff_ms)) // [R12]
                            next_fb_state[i] = SBC_FB_FAULT; // [R16]
                        else if (div_cnt[i] == 17'(CYC_PER_MS - 1))
                        begin
                            next_div_cnt[i] = 17'h0;
                            next_ms_cnt[i]  = ms_cnt[i] + 17'h1;
                        end
                        else
                            next_div_cnt[i] = div_cnt[i] + 17'h1;
                        // a new change restarts the wait, never hides a fault
                        if (drive[i] != next_drive[i] && next_fb_state[i] != SBC_FB_FAULT)
                        begin
                            next_fb_state[i] = SBC_FB_WAIT;
                            next_ms_cnt[i]  = 17'h0;
                            next_div_cnt[i] = 17'h0;
                        end
                    end
                    SBC_FB_FAULT:
                        next_err[i] = 1'h1; // [R16]
                    default:
                        next_fb_state[i] = SBC_FB_IDLE;
                endcase
                if (next_fb_state[i] == SBC_FB_FAULT)
                    next_err[i] = 1'h1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fb_state[0]    <= SBC_FB_IDLE;
            fb_state[1]    <= SBC_FB_IDLE;
            ms_cnt[0]      <= 17'h0;
            ms_cnt[1]      <= 17'h0;
            div_cnt[0]     <= 17'h0;
            div_cnt[1]     <= 17'h0;
            FEEDBACK_ERROR <= 2'h0;
        end
        else
        begin
            fb_state       <= next_fb_state;
            ms_cnt[0]      <= next_ms_cnt[0];
            ms_cnt[1]      <= next_ms_cnt[1];
            div_cnt[0]     <= next_div_cnt[0];
            div_cnt[1]     <= next_div_cnt[1];
            FEEDBACK_ERROR <= next_err;
        end
    end

    // output mapping
    always_comb
    begin
        if (BLK0_TYPE == `SBC_BLK_2POLE) // [R15]
        begin
            next_two_term = drive[0];
            next_out      = {drive[1], 1'h0}; // [R14]
        end
        else
        begin
            next_two_term = 1'h0;
            next_out      = drive; // [R14] [R13]
        end
        // reaction follows the registered error flags one cycle later
        next_reaction = |FEEDBACK_ERROR; // [R16]
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            TWO_TERMINAL_BRAKE_OUT <= 1'h0;
            BRAKE_DRIVE_OUT        <= 2'h0;
            ERROR_REACTION         <= 1'h0;
        end
        else
        begin
            TWO_TERMINAL_BRAKE_OUT <= next_two_term;
            BRAKE_DRIVE_OUT        <= next_out;
            ERROR_REACTION         <= next_reaction;
        end
    end

    // assertions
    sequence s_torque_off;
        TORQUE_OFF_STATE ##1 1'b1;
    endsequence

    a_torque_off_brake: assert property (@(posedge CLK) disable iff (!RST_N) // [R01]
        s_torque_off |=> (BRAKE_DRIVE_OUT[1] == 1'b0))
        else $error("brake not engaged after torque off");

    a_stop_brake: assert property (@(posedge CLK) disable iff (!RST_N) // [R07]
        CONTROLLED_STOP_ONE ##1 TORQUE_OFF_STATE |=> drive == 2'h0)
        else $error("stop did not engage brake");

    a_release_default: assert property (@(posedge CLK) disable iff (!RST_N) // [R03]
        (!TORQUE_OFF_STATE && !CONTROLLED_STOP_ONE && !CFG[1].pass_en && NUM_BLOCKS > 1)
        |=> drive[1])
        else $error("brake not released while inactive");

    a_pass_follow: assert property (@(posedge CLK) disable iff (!RST_N) // [R06]
        (!TORQUE_OFF_STATE && !CONTROLLED_STOP_ONE && CFG[1].pass_en && SAFE_RUN_STATE
         && NUM_BLOCKS > 1) |=> drive[1] == $past(DRIVE_RELEASE_REQ))
        else $error("output did not follow drive request");

    a_pass_ignored: assert property (@(posedge CLK) disable iff (!RST_N) // [R05]
        (TORQUE_OFF_STATE && CFG[1].pass_en && DRIVE_RELEASE_REQ) |=> ##1 !BRAKE_DRIVE_OUT[1])
        else $error("request passed during torque off");

    a_fbk_disabled: assert property (@(posedge CLK) disable iff (!RST_N) // [R08]
        (!CFG[0].fbk_en && !CFG[1].fbk_en) ##1 (!CFG[0].fbk_en && !CFG[1].fbk_en)
        |=> ##1 !ERROR_REACTION)
        else $error("error raised with feedback disabled");

    a_bad_contact: assert property (@(posedge CLK) disable iff (!RST_N) // [R11]
        (CFG[0].fbk_en && fb_state[0] == SBC_FB_IDLE && !cfg_ok[0]) |=> FEEDBACK_ERROR[0])
        else $error("bad contact type not flagged");

    a_fbk_timeout: assert property (@(posedge CLK) disable iff (!RST_N) // [R12]
        (CFG[0].fbk_en && fb_state[0] == SBC_FB_WAIT && BRAKE_FEEDBACK_IN[0] != expect_fb[0]
         && ms_cnt[0] >= (expect_fb[0] ? CFG[0].ton_ms : CFG[0].toff_ms))
        |=> FEEDBACK_ERROR[0] ##1 ERROR_REACTION)
        else $error("feedback timeout not flagged");

    // block 0 lands on exactly one output kind
    a_block0_map: assert property (@(posedge CLK) disable iff (!RST_N) // [R14] [R15]
        1'b1 |=> (BLK0_TYPE == `SBC_BLK_2POLE)
            ? (TWO_TERMINAL_BRAKE_OUT == $past(drive[0]) && !BRAKE_DRIVE_OUT[0])
            : (BRAKE_DRIVE_OUT[0] == $past(drive[0]) && !TWO_TERMINAL_BRAKE_OUT))
        else $error("block 0 drives the wrong output");

    a_torque_off_two: assert property (@(posedge CLK) disable iff (!RST_N) // [R01] [R02]
        s_torque_off |=> !TWO_TERMINAL_BRAKE_OUT && (BRAKE_DRIVE_OUT == 2'h0))
        else $error("an output stayed released in torque off");

    a_unused_block: assert property (@(posedge CLK) disable iff (!RST_N) // [R13]
        (NUM_BLOCKS < 2) |-> (drive[1] == 1'h0) && !FEEDBACK_ERROR[1])
        else $error("unused block is active");

    sequence s_fb_change;
        CFG[0].fbk_en && cfg_ok[0] && fb_state[0] == SBC_FB_IDLE && drive[0] != next_drive[0];
    endsequence

    a_wait_start: assert property (@(posedge CLK) disable iff (!RST_N) // [R16]
        s_fb_change |=> fb_state[0] == SBC_FB_WAIT && ms_cnt[0] == 17'h0)
        else $error("feedback wait not started");

    a_wait_done: assert property (@(posedge CLK) disable iff (!RST_N) // [R12]
        (CFG[0].fbk_en && fb_state[0] == SBC_FB_WAIT && BRAKE_FEEDBACK_IN[0] == expect_fb[0]
         && drive[0] == next_drive[0]) |=> fb_state[0] == SBC_FB_IDLE)
        else $error("matched feedback did not end the wait");

    a_div_bound: assert property (@(posedge CLK) disable iff (!RST_N) // [R12]
        div_cnt[0] <= 17'(CYC_PER_MS - 1))
        else $error("millisecond divider out of range");

    // a timeout decided in the wait state must reach the fault state
    sequence s_fb_timeout;
        CFG[0].fbk_en && fb_state[0] == SBC_FB_WAIT && BRAKE_FEEDBACK_IN[0] != expect_fb[0]
        && ms_cnt[0] >= (expect_fb[0] ? CFG[0].ton_ms : CFG[0].toff_ms);
    endsequence

    a_fault_entered: assert property (@(posedge CLK) disable iff (!RST_N) // [R16]
        s_fb_timeout |=> fb_state[0] == SBC_FB_FAULT)
        else $error("timeout did not enter fault");

    a_error_sticky: assert property (@(posedge CLK) disable iff (!RST_N) // [R16]
        FEEDBACK_ERROR[0] && CFG[0].fbk_en |=> FEEDBACK_ERROR[0])
        else $error("feedback error cleared while enabled");

    a_error_reaction: assert property (@(posedge CLK) disable iff (!RST_N) // [R16]
        (FEEDBACK_ERROR != 2'h0) |=> ERROR_REACTION)
        else $error("error reaction missing");

    a_no_false_reaction: assert property (@(posedge CLK) disable iff (!RST_N) // [R16]
        (FEEDBACK_ERROR == 2'h0) |=> !ERROR_REACTION)
        else $error("error reaction without feedback error");

endmodule // sbc_brake_ctrl

// ### sbc_brake_model.sv
// Purpose: braking device model returning feedback for one brake block
// Assumes: feedback lags the brake drive by DELAY cycles plus one
// Notes:   stuck freezes the feedback to make the block miss its delay
`include "sbc_params.svh"
module sbc_brake_model
    import sbc_pkg::*;
#(
    parameter int DELAY = 6
)(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // brake drive and fault control
    input  wire logic         drive,
    input  wire sbc_contact_t contact,
    input  wire logic         stuck,
    // feedback to the block
    output logic              feedback
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DELAY-1:0] pipe;
    logic             nc;
    assign nc = (contact == `SBC_CONTACT_NC);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pipe     <= '0;
            feedback <= nc;
        end
        else
        begin
            pipe <= {pipe[DELAY-2:0], drive};
            if (!stuck)
                feedback <= nc ? ~pipe[DELAY-1] : pipe[DELAY-1];
        end
    end
endmodule // sbc_brake_model

// ### sbc_params.svh
// Purpose: constants for the safe brake output control block
// Assumes: 125 MHz clock
// Notes:   times in ms, cycle counts derived
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
`define SBC_CLK_HZ          125000000
`define SBC_CYC_PER_MS      (`SBC_CLK_HZ / 1000)
`define SBC_DELAY_MAX_MS    120000
`define SBC_DELAY_DEF_MS    20
`define SBC_CONTACT_NO      2'h1
`define SBC_CONTACT_NC      2'h2
`define SBC_NUM_BLOCKS      2
`define SBC_BLK_1POLE       1'h0
`define SBC_BLK_2POLE       1'h1
`endif

// ### sbc_pkg.sv
// Purpose: types for the safe brake output control block
// Assumes: nothing
// Notes:   one config struct per brake block
package sbc_pkg;
    typedef logic [1:0] sbc_contact_t;
    typedef logic [16:0] sbc_ms_t;
    typedef struct packed {
        logic         pass_en;
        logic         fbk_en;
        sbc_contact_t contact;
        sbc_ms_t      ton_ms;
        sbc_ms_t      toff_ms;
    } sbc_cfg_s;
    typedef enum logic [1:0] {
        SBC_FB_IDLE  = 2'b00,
        SBC_FB_WAIT  = 2'b01,
        SBC_FB_FAULT = 2'b11
    } sbc_fb_e;
endpackage
